// File: design/irq_priority_field_bank.sv
// Behaviour
// [R1] each source has a 3-bit level field, code 111 is level 7, the highest priority.
// [R2] code 001 gives the source level 1, the lowest level that can still raise a request.
// [R3] code 000 disables the source so it is never presented to the core.
// [R4] bits outside the priority fields read as zero and ignore writes.
// [R5] every implemented field resets to 100 (level 4) and stays readable and writable.
// [R6] fields sit in bits 14..12, 10..8, 6..4 and 2..0; bits 15, 11, 7 and 3 are empty.
// [R7] the fifth register holds only the first external interrupt field, in bits 2..0.
// [R8] crypto rollover and buffer-free levels are independent fields at 14..12 and 10..8 of the eighth register.
// [R9] among pending sources the largest nonzero level is presented, ties going to the lowest slot.
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module irq_priority_field_bank
  import irq_prio_pkg::*;
(
  // clock, reset, freeze
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  input  wire logic               ce,
  // wishbone classic slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [ADDR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // flag-and-enable state of each slot, from same-clock logic
  input  wire logic [NUM_SLOTS-1:0] irq_pending,
  // resolved request to the core
  output irq_req_t                irq_req_q
);

  // ========================================================================
  // address decode

  // word map, fields at 14..12, 10..8, 6..4 and 2..0 from left to right:
  //   0x00  -, dma_chan1, converter, serial1_tx
  //   0x04  pin_change, comparator, twowire1_master, twowire1_slave
  //   0x08  -, -, -, ext_irq1
  //   0x0c  timer_four, compare_out4, compare_out3, dma_chan2
  //   0x10  serial2_tx, serial2_rx, ext_irq2, timer_five
  //   0x14  crypto_rollover, crypto_buffer_free, sync_serial2_tx, sync_serial2_general
  //   0x18  capture5, capture4, capture3, dma_chan3
  // anything else answers with zero data and drops writes, so software probing is harmless

  // maps a byte address to a register index; hit is low for unmapped words
  function automatic logic [IDX_W:0] decode_reg(input logic [ADDR_W-1:0] adr);
    logic [IDX_W:0] res;
    res = '0;
    if (adr == OFF_SOURCE_PRIORITY_3)
      res = {1'b1, 3'h0};
    else if (adr == OFF_SOURCE_PRIORITY_4)
      res = {1'b1, 3'h1};
    else if (adr == OFF_SOURCE_PRIORITY_5)
      res = {1'b1, 3'h2};
    else if (adr == OFF_SOURCE_PRIORITY_6)
      res = {1'b1, 3'h3};
    else if (adr == OFF_SOURCE_PRIORITY_7)
      res = {1'b1, 3'h4};
    else if (adr == OFF_SOURCE_PRIORITY_8)
      res = {1'b1, 3'h5};
    else if (adr == OFF_SOURCE_PRIORITY_9)
      res = {1'b1, 3'h6};
    else
      res = '0;
    return res;
  endfunction

  logic [IDX_W:0]   dec;
  logic             hit;
  logic [IDX_W-1:0] idx;
  logic             req_new;
  logic [15:0]      lane_mask;

  assign dec     = decode_reg(wb_adr_i);
  assign hit     = dec[IDX_W];
  assign idx     = dec[IDX_W-1:0];
  // a request is taken once; the ack cycle itself is not a new request
  assign req_new = ce && wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // ========================================================================
  // priority registers

  logic [REG_W-1:0] prio_q [NUM_REGS];

  // only implemented field bits are ever stored, so empty bits stay zero
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int r = 0; r < NUM_REGS; r++)
        prio_q[r] <= RESET_PATTERN & IMPL_MASK[r]; // R5
    end
    else if (req_new && wb_we_i && hit)
    begin
      // writes land only on implemented bits of enabled lanes
      prio_q[idx] <= (prio_q[idx] & ~(IMPL_MASK[idx] & lane_mask))
                   | (wb_dat_i[15:0] & IMPL_MASK[idx] & lane_mask); // R4 R6 R7 R8
    end
  end

  // ========================================================================
  // bus answer: ack one cycle after the request, unmapped reads give zero

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      wb_ack_o <= 1'b0;
    else if (ce)
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  // read data is captured with the ack so it comes straight from a flop
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      wb_dat_o <= '0;
    else if (req_new && !wb_we_i && hit)
      wb_dat_o <= {16'h0000, prio_q[idx] & IMPL_MASK[idx]}; // R4
    else if (req_new)
      wb_dat_o <= '0;
  end

  // ========================================================================
  // level extraction per slot

  logic [FIELD_W-1:0] lvl [NUM_SLOTS];

  genvar gr, gs;
  generate
    for (gr = 0; gr < NUM_REGS; gr++)
    begin : g_reg
      for (gs = 0; gs < SLOTS; gs++)
      begin : g_slot
        // unimplemented slots hold zero and so behave as disabled
        assign lvl[gr*SLOTS+gs] = prio_q[gr][gs*SLOT_PITCH +: FIELD_W]; // R6
      end
    end
  endgenerate

  // ========================================================================
  // arbitration

  logic [FIELD_W-1:0] best_lvl;
  logic [SLOT_W-1:0]  best_src;

  // strict greater-than keeps the lowest slot on a tie
  always_comb
  begin
    best_lvl = LEVEL_OFF;
    best_src = '0;
    for (int i = 0; i < NUM_SLOTS; i++)
    begin
      if (irq_pending[i] && lvl[i] != LEVEL_OFF && lvl[i] > best_lvl) // R3 R9
      begin
        best_lvl = lvl[i];
        best_src = SLOT_W'(i);
      end
    end
  end

  // the core sees a registered request; a level of zero never reaches it
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      irq_req_q <= '0;
    else if (ce)
    begin
      irq_req_q.valid  <= best_lvl != LEVEL_OFF; // R3
      irq_req_q.level  <= best_lvl;              // R1 R2 R9
      irq_req_q.source <= best_src;
    end
  end

  // ========================================================================
  // checks

  // independent maximum for comparison against the arbiter
  logic [FIELD_W-1:0] chk_max;
  logic               chk_top;
  always_comb
  begin
    chk_max = LEVEL_OFF;
    chk_top = 1'b0;
    for (int i = 0; i < NUM_SLOTS; i++)
    begin
      if (irq_pending[i] && lvl[i] > chk_max)
        chk_max = lvl[i];
      if (irq_pending[i] && lvl[i] == LEVEL_MAX)
        chk_top = 1'b1;
    end
  end

  // cleared at the first enabled edge after reset
  logic fresh_q;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      fresh_q <= 1'b1;
    else if (ce)
      fresh_q <= 1'b0;
  end

  // lanes and field bits that the current write may touch
  logic [REG_W-1:0] chk_wmask;
  assign chk_wmask = IMPL_MASK[idx] & lane_mask;

  // level and pending state of the source picked at the last enabled edge
  logic [FIELD_W-1:0] seen_lvl_q;
  logic               seen_pend_q;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      seen_lvl_q  <= LEVEL_OFF;
      seen_pend_q <= 1'b0;
    end
    else if (ce)
    begin
      seen_lvl_q  <= lvl[best_src];
      seen_pend_q <= irq_pending[best_src];
    end
  end

  // first pending slot at the top level, found apart from the arbiter
  logic [SLOT_W-1:0] chk_first;
  logic              chk_found;
  always_comb
  begin
    chk_first = '0;
    chk_found = 1'b0;
    for (int i = 0; i < NUM_SLOTS; i++)
    begin
      if (!chk_found && irq_pending[i] && chk_max != LEVEL_OFF && lvl[i] == chk_max)
      begin
        chk_first = SLOT_W'(i);
        chk_found = 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  chk_reset_level_four: assert property ( // R5
    fresh_q |-> (prio_q[0] == 16'h0444 && prio_q[1] == 16'h4444 && prio_q[2] == 16'h0004 && prio_q[6] == 16'h4444))
    else $error("priority field not at level 4 after reset");

  chk_empty_bits_zero: assert property ( // R4
    wb_ack_o && !wb_we_i |-> wb_dat_o[31:15] == '0 && wb_dat_o[11] == 1'b0 && wb_dat_o[7] == 1'b0)
    else $error("unused bit read back nonzero");

  chk_gap_bit_three: assert property ( // R6
    req_new && wb_we_i && hit |=> prio_q[$past(idx)][3] == 1'b0 && prio_q[$past(idx)][15] == 1'b0)
    else $error("separator bit stored a written one");

  chk_fifth_reg_only: assert property ( // R7
    wb_ack_o && !wb_we_i && wb_adr_i == OFF_SOURCE_PRIORITY_5 |-> wb_dat_o[15:3] == '0)
    else $error("fifth register shows bits above its one field");

  chk_crypto_fields_set: assert property ( // R8
    req_new && wb_we_i && wb_adr_i == OFF_SOURCE_PRIORITY_8 && wb_sel_i[1]
    |=> prio_q[5][14:12] == $past(wb_dat_i[14:12]) && prio_q[5][10:8] == $past(wb_dat_i[10:8]))
    else $error("crypto level fields not written independently");

  chk_disabled_silent: assert property ( // R3
    irq_req_q.valid |-> irq_req_q.level != LEVEL_OFF && seen_lvl_q == irq_req_q.level && seen_pend_q)
    else $error("request presented for a disabled or idle source");

  chk_max_level_wins: assert property ( // R9
    ce |=> irq_req_q.level == $past(chk_max) && irq_req_q.valid == ($past(chk_max) != LEVEL_OFF))
    else $error("presented level is not the largest pending");

  chk_top_is_seven: assert property ( // R1
    ce && chk_top |=> irq_req_q.valid && irq_req_q.level == LEVEL_MAX)
    else $error("level 7 source not presented at level 7");

  chk_level_one_rises: assert property ( // R2
    ce && chk_max == LEVEL_MIN |=> irq_req_q.valid && irq_req_q.level == LEVEL_MIN)
    else $error("level 1 source failed to raise a request");

  chk_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  chk_ack_needs_cycle: assert property (
    ce && !wb_cyc_i |=> !wb_ack_o)
    else $error("ack raised with no bus cycle");

  // register file and bus checks; each request in an antecedent is one the bench really makes
  chk_reset_rest_four: assert property ( // R5
    fresh_q |-> prio_q[3] == 16'h4444 && prio_q[4] == 16'h4444 && prio_q[5] == 16'h4444)
    else $error("middle registers not at level 4 after reset");

  chk_write_lands: assert property ( // R5
    req_new && wb_we_i && hit
    |=> (prio_q[$past(idx)] & $past(chk_wmask)) == ($past(wb_dat_i[15:0]) & $past(chk_wmask)))
    else $error("written field bits did not land");

  chk_lane_kept: assert property ( // R4
    req_new && wb_we_i && hit
    |=> (prio_q[$past(idx)] & ~$past(chk_wmask)) == ($past(prio_q[idx]) & ~$past(chk_wmask)))
    else $error("bits outside the written lanes changed");

  chk_unmapped_ignored: assert property ( // R4
    req_new && wb_we_i && !hit
    |=> prio_q[0] == $past(prio_q[0]) && prio_q[1] == $past(prio_q[1]) && prio_q[2] == $past(prio_q[2])
        && prio_q[3] == $past(prio_q[3]) && prio_q[4] == $past(prio_q[4]) && prio_q[5] == $past(prio_q[5])
        && prio_q[6] == $past(prio_q[6]))
    else $error("write to an unmapped word changed a register");

  chk_unmapped_zero: assert property ( // R4
    req_new && !wb_we_i && !hit |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");

  chk_read_is_stored: assert property ( // R6
    req_new && !wb_we_i && hit |=> wb_dat_o == {16'h0000, $past(prio_q[idx])})
    else $error("read data differs from the stored word");

  chk_dat_upper_zero: assert property ( // R4
    wb_dat_o[31:16] == 16'h0000)
    else $error("upper read half not zero");

  chk_ack_after_take: assert property (
    req_new |=> wb_ack_o)
    else $error("bus request not answered in the next cycle");

  chk_freeze_holds: assert property (
    !ce |=> $stable(irq_req_q) && $stable(wb_ack_o) && $stable(wb_dat_o))
    else $error("state moved while the clock enable was low");

  // request checks; the helpers above give a view of the arbiter of their own
  chk_idle_no_request: assert property ( // R3
    ce && irq_pending == '0 |=> !irq_req_q.valid)
    else $error("request presented with nothing pending");

  chk_tie_lowest_slot: assert property ( // R9
    ce && chk_found |=> irq_req_q.source == $past(chk_first))
    else $error("tie not resolved toward the lowest slot");

  cov_write_then_ack: cover property (req_new && wb_we_i && hit ##1 wb_ack_o);
  cov_unmapped_read: cover property (req_new && !wb_we_i && !hit ##1 wb_ack_o);
  cov_top_request: cover property (irq_req_q.valid && irq_req_q.level == LEVEL_MAX);
  cov_tie_pending: cover property (ce && irq_pending[SYNC_SERIAL2_TX_LEVEL_SLOT]
    && irq_pending[CRYPTO_BUFFER_FREE_LEVEL_SLOT] && lvl[SYNC_SERIAL2_TX_LEVEL_SLOT] != LEVEL_OFF
    && lvl[SYNC_SERIAL2_TX_LEVEL_SLOT] == lvl[CRYPTO_BUFFER_FREE_LEVEL_SLOT]);
  cov_frozen_request: cover property (!ce && wb_cyc_i && wb_stb_i);

endmodule

// File: include/irq_prio_pkg.sv
// ==========================================================================
// shared constants and types for the priority field bank
package irq_prio_pkg;

  // ========================================================================
  // geometry
  localparam int NUM_REGS   = 7;
  localparam int SLOTS      = 4;
  localparam int NUM_SLOTS  = 28;
  localparam int SLOT_W     = 5;
  localparam int FIELD_W    = 3;
  localparam int SLOT_PITCH = 4;
  localparam int REG_W      = 16;
  localparam int ADDR_W     = 8;
  localparam int IDX_W      = 3;

  // ========================================================================
  // level codes
  localparam logic [2:0] LEVEL_OFF = 3'h0;
  localparam logic [2:0] LEVEL_MIN = 3'h1;
  localparam logic [2:0] LEVEL_MAX = 3'h7;

  // every implemented field powers up at level 4
  localparam logic [15:0] RESET_PATTERN = 16'h4444;

  // ========================================================================
  // register byte addresses, one aligned word each
  localparam logic [7:0] OFF_SOURCE_PRIORITY_3 = 8'h00;
  localparam logic [7:0] OFF_SOURCE_PRIORITY_4 = 8'h04;
  localparam logic [7:0] OFF_SOURCE_PRIORITY_5 = 8'h08;
  localparam logic [7:0] OFF_SOURCE_PRIORITY_6 = 8'h0c;
  localparam logic [7:0] OFF_SOURCE_PRIORITY_7 = 8'h10;
  localparam logic [7:0] OFF_SOURCE_PRIORITY_8 = 8'h14;
  localparam logic [7:0] OFF_SOURCE_PRIORITY_9 = 8'h18;

  // implemented field bits per register, index 0 is source_priority_3
  localparam logic [15:0] IMPL_MASK [NUM_REGS] = '{
    16'h0777, 16'h7777, 16'h0007, 16'h7777, 16'h7777, 16'h7777, 16'h7777
  };

  // ========================================================================
  // source slots: slot = register index * 4 + field (field 0 is bits 2..0)
  localparam logic [4:0] SERIAL1_TX_LEVEL_SLOT           = 5'h00;
  localparam logic [4:0] CONVERTER_LEVEL_SLOT            = 5'h01;
  localparam logic [4:0] DMA_CHAN1_LEVEL_SLOT            = 5'h02;
  localparam logic [4:0] TWOWIRE1_SLAVE_LEVEL_SLOT       = 5'h04;
  localparam logic [4:0] TWOWIRE1_MASTER_LEVEL_SLOT      = 5'h05;
  localparam logic [4:0] COMPARATOR_LEVEL_SLOT           = 5'h06;
  localparam logic [4:0] PIN_CHANGE_LEVEL_SLOT           = 5'h07;
  localparam logic [4:0] EXT_IRQ1_LEVEL_SLOT             = 5'h08;
  localparam logic [4:0] DMA_CHAN2_LEVEL_SLOT            = 5'h0c;
  localparam logic [4:0] COMPARE_OUT3_LEVEL_SLOT         = 5'h0d;
  localparam logic [4:0] COMPARE_OUT4_LEVEL_SLOT         = 5'h0e;
  localparam logic [4:0] TIMER_FOUR_LEVEL_SLOT           = 5'h0f;
  localparam logic [4:0] TIMER_FIVE_LEVEL_SLOT           = 5'h10;
  localparam logic [4:0] EXT_IRQ2_LEVEL_SLOT             = 5'h11;
  localparam logic [4:0] SERIAL2_RX_LEVEL_SLOT           = 5'h12;
  localparam logic [4:0] SERIAL2_TX_LEVEL_SLOT           = 5'h13;
  localparam logic [4:0] SYNC_SERIAL2_GENERAL_LEVEL_SLOT = 5'h14;
  localparam logic [4:0] SYNC_SERIAL2_TX_LEVEL_SLOT      = 5'h15;
  localparam logic [4:0] CRYPTO_BUFFER_FREE_LEVEL_SLOT   = 5'h16;
  localparam logic [4:0] CRYPTO_ROLLOVER_LEVEL_SLOT      = 5'h17;
  localparam logic [4:0] DMA_CHAN3_LEVEL_SLOT            = 5'h18;
  localparam logic [4:0] CAPTURE3_LEVEL_SLOT             = 5'h19;
  localparam logic [4:0] CAPTURE4_LEVEL_SLOT             = 5'h1a;
  localparam logic [4:0] CAPTURE5_LEVEL_SLOT             = 5'h1b;

  // ========================================================================
  // request presented to the core
  typedef struct packed {
    logic       valid;
    logic [2:0] level;
    logic [4:0] source;
  } irq_req_t;

endpackage

// File: verification/core_model.sv
`timescale 1ns/1ps
// ==========================================================================
// core side: takes each request the bank presents
module core_model
  import irq_prio_pkg::*;
(
  // clock and reset
  input  wire logic     clk_sys,
  input  wire logic     rst_b,
  // request from the bank
  input  wire irq_req_t irq_req_q,
  // last request taken
  output irq_req_t      taken_q
);
  // latch only valid requests, so an idle cycle never wipes the last vector
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      taken_q <= '0;
    else if (irq_req_q.valid)
      taken_q <= irq_req_q;
endmodule

// File: verification/test_irq_priority_field_bank.sv
`timescale 1ns/1ps
// ==========================================================================
// self-checking bench for the priority field bank
module test_irq_priority_field_bank
  import irq_prio_pkg::*;
;
  // design inputs and outputs
  logic                 clk_sys = 1'b0;
  logic                 rst_b = 1'b0;
  logic                 ce = 1'b1;
  logic                 wb_cyc_i = 1'b0;
  logic                 wb_stb_i = 1'b0;
  logic                 wb_we_i = 1'b0;
  logic [ADDR_W-1:0]    wb_adr_i = '0;
  logic [3:0]           wb_sel_i = '0;
  logic [31:0]          wb_dat_i = '0;
  logic [31:0]          wb_dat_o;
  logic                 wb_ack_o;
  logic [NUM_SLOTS-1:0] irq_pending = '0;
  irq_req_t             irq_req_q;
  irq_req_t             taken_q;
  int                   bad_count = 0;
  int                   n_tests = 0;
  logic [15:0]          rd;

  // 25 MHz system clock
  always #20 clk_sys = ~clk_sys;

  irq_priority_field_bank i_irq_priority_field_bank (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_pending(irq_pending), .irq_req_q(irq_req_q)
  );

  core_model i_core_model (.clk_sys(clk_sys), .rst_b(rst_b), .irq_req_q(irq_req_q), .taken_q(taken_q));

  // ==========================================================================
  // verdict, reached from the main sequence or the watchdog
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // compare tasks, one per kind of result
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask

  task automatic chk_req(input irq_req_t got, input irq_req_t exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("[ERR] %0t request %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask

  // one classic cycle; entering on a fresh edge keeps cyc low at least a cycle
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [15:0] wd, output logic [15:0] rd_o);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0000, wd};
    // no local limit: only the watchdog may end a wait for the answer
    do
    begin
      @(posedge clk_sys);
    end
    while (wb_ack_o !== 1'b1);
    rd_o = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    for (int i = 0; i < NUM_REGS; i++)
    begin
      wb_xfer(1'b0, 8'(i * 4), 16'h0000, rd);
      chk16(rd, IMPL_MASK[i] & RESET_PATTERN);
    end
    wb_xfer(1'b0, 8'h1c, 16'h0000, rd);
    chk16(rd, 16'h0000);
    chk_req(irq_req_q, '0);
    $display("reset values done");
  endtask

  task automatic t_rw();
    for (int i = 0; i < NUM_REGS; i++)
    begin
      wb_xfer(1'b1, 8'(i * 4), 16'hffff, rd);
      wb_xfer(1'b0, 8'(i * 4), 16'h0000, rd);
      chk16(rd, IMPL_MASK[i]);
      wb_xfer(1'b1, 8'(i * 4), 16'h0000, rd);
      wb_xfer(1'b0, 8'(i * 4), 16'h0000, rd);
      chk16(rd, 16'h0000);
    end
    wb_xfer(1'b1, 8'h1c, 16'hffff, rd);
    wb_xfer(1'b0, 8'h1c, 16'h0000, rd);
    chk16(rd, 16'h0000);
    $display("read write done");
  endtask

  // crypto fields in the eighth register against pending slots 23..21
  task automatic t_arb();
    logic [15:0] lv [6] = '{16'h3500, 16'h7100, 16'h0100, 16'h0000, 16'h5550, 16'h5550};
    logic [2:0]  pd [6] = '{3'h6, 3'h6, 3'h6, 3'h7, 3'h7, 3'h6};
    irq_req_t    ex [6] = '{'{1'b1, 3'h5, 5'h16}, '{1'b1, 3'h7, 5'h17}, '{1'b1, 3'h1, 5'h16},
                            '{1'b0, 3'h0, 5'h00}, '{1'b1, 3'h5, 5'h15}, '{1'b1, 3'h5, 5'h16}};
    for (int i = 0; i < 6; i++)
    begin
      wb_xfer(1'b1, OFF_SOURCE_PRIORITY_8, lv[i], rd);
      irq_pending[23:21] <= pd[i];
      repeat (2) @(posedge clk_sys);
      chk_req(irq_req_q, ex[i]);
    end
    // the core model latches one edge after the request settles
    @(posedge clk_sys);
    chk_req(taken_q, ex[5]);
    $display("arbitration done");
  endtask

  // a low enable freezes the request and holds a bus request unanswered
  task automatic t_freeze();
    @(posedge clk_sys);
    ce          <= 1'b0;
    irq_pending <= '0;
    fork
      wb_xfer(1'b1, OFF_SOURCE_PRIORITY_8, 16'h0000, rd);
      begin
        repeat (4) @(posedge clk_sys);
        chk_req(irq_req_q, irq_req_t'{1'b1, 3'h5, 5'h16});
        ce <= 1'b1;
      end
    join
    wb_xfer(1'b0, OFF_SOURCE_PRIORITY_8, 16'h0000, rd);
    chk16(rd, 16'h0000);
    chk_req(irq_req_q, '0);
    $display("freeze done");
  endtask

  // a second reset in mid-run brings every field back to level 4
  task automatic t_rereset();
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk_req(irq_req_q, '0);
    rst_b <= 1'b1;
    wb_xfer(1'b0, OFF_SOURCE_PRIORITY_8, 16'h0000, rd);
    chk16(rd, 16'h4444);
    wb_xfer(1'b0, OFF_SOURCE_PRIORITY_5, 16'h0000, rd);
    chk16(rd, 16'h0004);
    $display("second reset done");
  endtask

  // ==========================================================================
  // main sequence and watchdog
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_rw();
    t_arb();
    t_freeze();
    t_rereset();
    finish_test();
  end

  initial
  begin
    repeat (3000) @(posedge clk_sys);
    bad_count++;
    finish_test();
  end
endmodule
